/* File: design/cto_top.sv */
// Purpose: one compare module of the counter array in high-speed output mode
// Assumes: Avalon-MM slave with waitrequest, one clock, ce freezes all state
// Notes:   counter array is kept here; output pin toggles on each compare match
`include "cto_defs.svh"

module cto_top #(
    parameter int ADDR_W = `CTO_ADDR_W
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              ce,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output cto_pkg::cto_data_t     readdata,
    output logic                   waitrequest,
    output logic                   irq,
    output logic                   module_output_pin
);
    import cto_pkg::*;

    // ======================================================================
    // state
    cto_bus_state_t bus_state;
    cto_bus_state_t next_bus_state;
    logic           next_waitrequest;
    cto_data_t      next_readdata;

    cto_mode_t      mode;
    cto_mode_t      next_mode;
    cto_byte_t      cmp_lo;
    cto_byte_t      next_cmp_lo;
    cto_byte_t      cmp_hi;
    cto_byte_t      next_cmp_hi;
    logic           run;
    logic           next_run;
    logic           irq_en;
    logic           next_irq_en;
    logic           flag;
    logic           next_flag;
    cto_count_t     count;
    cto_count_t     next_count;
    logic           next_pin;
    logic           next_irq;

    logic           acc_wr;
    logic           hso;
    logic           hit;
    logic           flag_set;
    logic           flag_clr;

    cto_cmp_if      cmp_bus ();

    // ======================================================================
    // helpers
    function automatic logic at(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    function automatic cto_data_t bit_word(input logic b);
        return {31'h00000000, b};
    endfunction

    // read mux, unmapped and write-only offsets read as zero
    function automatic cto_data_t rd_mux(input logic [ADDR_W-1:0] a);
        cto_data_t d;
        d = `CTO_RST_DATA;
        if (at(a, `CTO_OFS_MODE)) begin
            d[`CTO_MODE_CMP_EN]    = mode.comparator_enable;
            d[`CTO_MODE_MATCH_SEL] = mode.match_select;
            d[`CTO_MODE_TOGGLE]    = mode.toggle_select;
        end
        if (at(a, `CTO_OFS_CMP_LO)) begin
            d[7:0] = cmp_lo;
        end
        if (at(a, `CTO_OFS_CMP_HI)) begin
            d[7:0] = cmp_hi;
        end
        if (at(a, `CTO_OFS_CTRL)) begin
            d[`CTO_CTRL_RUN]  = run;
            d[`CTO_CTRL_FLAG] = flag;
        end
        if (at(a, `CTO_OFS_STATUS)) begin
            d = bit_word(flag);
        end
        if (at(a, `CTO_OFS_IRQ_EN)) begin
            d = bit_word(irq_en);
        end
        if (at(a, `CTO_OFS_COUNT)) begin
            d[15:0] = count;
        end
        if (at(a, `CTO_OFS_PIN)) begin
            d = bit_word(module_output_pin);
        end
        return d;
    endfunction

    // ======================================================================
    // comparator
    assign cmp_bus.count      = count;
    assign cmp_bus.cmp_value  = {cmp_hi, cmp_lo};
    assign cmp_bus.count_step = run;
    assign hit                = cmp_bus.hit;

    cto_match u_match (
        .bus (cmp_bus)
    );

    // ======================================================================
    // bus slave: one wait cycle, then waitrequest low for exactly one cycle
    // ce low during the ack cycle stretches it, but the access still lands
    // only on an enabled edge; keep ce high across an access
    always_comb begin
        next_bus_state = bus_state;
        next_readdata  = readdata;
        case (bus_state)
            bus_idle: begin
                if (read || write) begin
                    next_bus_state = bus_ack;
                    next_readdata  = read ? rd_mux(address) : `CTO_RST_DATA;
                end
            end
            bus_ack: begin
                next_bus_state = bus_idle;
            end
            default: begin
                next_bus_state = bus_idle;
            end
        endcase
        next_waitrequest = (next_bus_state != bus_ack);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bus_state   <= bus_idle;
            waitrequest <= 1'b1;
            readdata    <= `CTO_RST_DATA;
        end else if (ce) begin
            bus_state   <= next_bus_state;
            waitrequest <= next_waitrequest;
            readdata    <= next_readdata;
        end
    end

    // ======================================================================
    // registers, counter, flag and pin
    // a write lands at the edge where waitrequest is sampled low
    assign acc_wr = write && !waitrequest && byteenable[0];

    always_comb begin
        next_mode   = mode;
        next_cmp_lo = cmp_lo;
        next_cmp_hi = cmp_hi;
        next_run    = run;
        next_irq_en = irq_en;
        flag_clr    = 1'b0;
        if (acc_wr && at(address, `CTO_OFS_MODE)) begin
            next_mode.comparator_enable = writedata[`CTO_MODE_CMP_EN];
            next_mode.match_select      = writedata[`CTO_MODE_MATCH_SEL];
            next_mode.toggle_select     = writedata[`CTO_MODE_TOGGLE];
        end
        if (acc_wr && at(address, `CTO_OFS_CMP_LO)) begin
            next_cmp_lo                 = writedata[7:0];
            next_mode.comparator_enable = 1'b0;
        end
        if (acc_wr && at(address, `CTO_OFS_CMP_HI)) begin
            next_cmp_hi                 = writedata[7:0];
            next_mode.comparator_enable = 1'b1;
        end
        if (acc_wr && at(address, `CTO_OFS_CTRL)) begin
            next_run = writedata[`CTO_CTRL_RUN];
        end
        if (acc_wr && at(address, `CTO_OFS_IRQ_EN)) begin
            next_irq_en = writedata[`CTO_STAT_MATCH];
        end
        if (acc_wr && at(address, `CTO_OFS_IRQ_CLR)) begin
            flag_clr = writedata[`CTO_STAT_MATCH];
        end

        hso      = mode.toggle_select && mode.match_select && mode.comparator_enable;
        flag_set = hit && mode.match_select && mode.comparator_enable;

        next_count = run ? count + 16'h0001 : count;

        // only software clears the flag; a match in the same cycle wins
        next_flag = flag;
        if (flag_clr) begin
            next_flag = 1'b0;
        end
        if (flag_set) begin
            next_flag = 1'b1;
        end

        // without the comparator enable the pin simply holds
        next_pin = module_output_pin ^ (hit && hso);

        next_irq = next_flag && next_irq_en;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode              <= '0;
            cmp_lo            <= `CTO_RST_BYTE;
            cmp_hi            <= `CTO_RST_BYTE;
            run               <= `CTO_RST_BIT;
            irq_en            <= `CTO_RST_BIT;
            flag              <= `CTO_RST_BIT;
            count             <= `CTO_RST_COUNT;
            module_output_pin <= `CTO_RST_BIT;
            irq               <= `CTO_RST_BIT;
        end else if (ce) begin
            mode              <= next_mode;
            cmp_lo            <= next_cmp_lo;
            cmp_hi            <= next_cmp_hi;
            run               <= next_run;
            irq_en            <= next_irq_en;
            flag              <= next_flag;
            count             <= next_count;
            module_output_pin <= next_pin;
            irq               <= next_irq;
        end
    end

    // ======================================================================
    // assertions
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence hso_match_s;
        ce && hso && hit;
    endsequence

    sequence lo_write_s;
        ce && acc_wr && at(address, `CTO_OFS_CMP_LO);
    endsequence

    sequence hi_write_s;
        ce && acc_wr && at(address, `CTO_OFS_CMP_HI);
    endsequence

    sequence match_land_s;
        ##1 (count == {$past(cmp_hi), $past(cmp_lo)});
    endsequence

    sequence clr_write_s;
        ce && acc_wr && at(address, `CTO_OFS_IRQ_CLR) && writedata[`CTO_STAT_MATCH];
    endsequence

    pin_toggle_a: assert property (
        hso_match_s |=> (module_output_pin != $past(module_output_pin)))
        else $error("pin did not toggle on a compare match");

    flag_set_a: assert property (
        hso_match_s |=> flag)
        else $error("match flag not set after a compare match");

    irq_level_a: assert property (
        irq == (flag && irq_en))
        else $error("interrupt does not follow enabled match flag");

    flag_sticky_a: assert property (
        flag && !(ce && flag_clr) |=> flag)
        else $error("match flag cleared without a software clear");

    hso_mode_a: assert property (
        ce && hit && !mode.toggle_select |=> $stable(module_output_pin))
        else $error("pin toggled without toggle select");

    pin_hold_a: assert property (
        !mode.comparator_enable |=> $stable(module_output_pin))
        else $error("pin changed while comparator disabled");

    lo_clear_a: assert property (
        lo_write_s |=> !mode.comparator_enable)
        else $error("low byte write did not clear comparator enable");

    hi_set_a: assert property (
        hi_write_s |=> mode.comparator_enable)
        else $error("high byte write did not set comparator enable");

    match_once_a: assert property (
        hso_match_s |-> match_land_s ##0 (flag && !$stable(module_output_pin)))
        else $error("toggle and flag not in the cycle the counter lands on compare");

    pin_cause_a: assert property (
        ce && !hit |=> $stable(module_output_pin))
        else $error("pin toggled without a match");

    bus_ack_a: assert property (
        ce && (read || write) && waitrequest && bus_state == bus_idle |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle after the request");

    // ======================================================================
    // assertions: clock enable, counter, match flag, waitrequest and register writes
    freeze_a: assert property (
        !ce |=> $stable(count) && $stable(module_output_pin) && $stable(flag))
        else $error("state moved while clock enable low");

    count_step_a: assert property (
        ce && run |=> count == $past(count) + 16'h0001)
        else $error("counter did not step by one");

    run_stop_a: assert property (
        ce && !run |=> $stable(count))
        else $error("counter moved while stopped");

    flag_cause_a: assert property (
        !flag && !(ce && hit && mode.match_select && mode.comparator_enable) |=> !flag)
        else $error("match flag set without an enabled match");

    flag_clear_a: assert property (
        clr_write_s ##0 !(hit && mode.match_select && mode.comparator_enable) |=> !flag)
        else $error("software clear did not clear the match flag");

    wait_one_a: assert property (
        ce && !waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    lo_data_a: assert property (
        lo_write_s |=> cmp_lo == $past(writedata[7:0]))
        else $error("compare low byte not stored");

    hi_data_a: assert property (
        hi_write_s |=> cmp_hi == $past(writedata[7:0]))
        else $error("compare high byte not stored");

    mode_data_a: assert property (
        ce && acc_wr && at(address, `CTO_OFS_MODE)
        |=> mode.toggle_select == $past(writedata[`CTO_MODE_TOGGLE]))
        else $error("toggle select not stored");
endmodule

/* File: pkg/cto_defs.svh */
// Purpose: offsets, field positions and reset values of the compare toggle output block
// Assumes: registers sit one per aligned 32-bit word, byte addressed
// Notes:   definitions only
`ifndef CTO_DEFS_SVH
`define CTO_DEFS_SVH

// ==========================================================================
// register offsets (byte addresses)
`define CTO_ADDR_W         8
`define CTO_OFS_MODE       8'h00
`define CTO_OFS_CMP_LO     8'h04
`define CTO_OFS_CMP_HI     8'h08
`define CTO_OFS_CTRL       8'h0C
`define CTO_OFS_STATUS     8'h10
`define CTO_OFS_IRQ_CLR    8'h14
`define CTO_OFS_IRQ_EN     8'h18
`define CTO_OFS_COUNT      8'h1C
`define CTO_OFS_PIN        8'h20

// ==========================================================================
// field positions
`define CTO_MODE_CMP_EN    0
`define CTO_MODE_MATCH_SEL 1
`define CTO_MODE_TOGGLE    2
`define CTO_CTRL_RUN       0
`define CTO_CTRL_FLAG      1
`define CTO_STAT_MATCH     0

// ==========================================================================
// reset values
`define CTO_RST_BYTE       8'h00
`define CTO_RST_COUNT      16'h0000
`define CTO_RST_BIT        1'b0
`define CTO_RST_DATA       32'h00000000

`endif

/* File: pkg/cto_pkg.sv */
// Purpose: types shared by the compare toggle output block
// Assumes: 16-bit counter array, byte-wide compare halves
// Notes:   constants live in cto_defs.svh
package cto_pkg;

    // ======================================================================
    // types
    typedef logic [31:0] cto_data_t;
    typedef logic [15:0] cto_count_t;
    typedef logic [7:0]  cto_byte_t;

    typedef struct packed {
        logic toggle_select;
        logic match_select;
        logic comparator_enable;
    } cto_mode_t;

    typedef enum {
        bus_idle,
        bus_ack
    } cto_bus_state_t;

endpackage

/* File: pkg/cto_cmp_if.sv */
// Purpose: carries counter and compare value to the comparator and the hit back
// Assumes: all signals on the block clock
// Notes:   hit is combinational
interface cto_cmp_if;
    import cto_pkg::*;

    cto_count_t count;
    cto_count_t cmp_value;
    logic       count_step;
    logic       hit;

    modport array (output count, output cmp_value, output count_step, input hit);
    modport cmp   (input count, input cmp_value, input count_step, output hit);
endinterface

/* File: design/cto_match.sv */
// Purpose: detects the counter stepping onto the compare value
// Assumes: count_step is high in the cycle whose edge increments the counter
// Notes:   purely combinational; the caller registers the effects
module cto_match (
    cto_cmp_if.cmp bus
);
    import cto_pkg::*;

    cto_count_t ahead;

    // ======================================================================
    // one hit per increment that lands on the compare value
    always_comb begin
        ahead   = bus.count + 16'h0001;
        bus.hit = bus.count_step && (ahead == bus.cmp_value);
    end
endmodule

/* File: verification/cto_pin_mon.sv */
// Purpose: far-side logic that samples the module output pin
// Assumes: pin is sampled on the block clock
// Notes:   counts level changes only; never drives anything back
module cto_pin_mon (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        module_output_pin,
    output logic      [15:0] toggles
);
    timeunit 1ns;
    timeprecision 1ps;

    logic last_level;

    // ==================================================================
    // change counter
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_level <= 1'b0;
            toggles    <= 16'h0000;
        end else begin
            last_level <= module_output_pin;
            if (module_output_pin !== last_level) begin
                toggles <= toggles + 16'h0001;
            end
        end
    end
endmodule

/* File: verification/testbench.sv */
// Purpose: self-checking bench for the compare toggle output block
// Assumes: 125 MHz clock, ce high except in the freeze test
// Notes:   counter is stopped while a new compare value is loaded
`include "cto_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import cto_pkg::*;

    logic       clk;
    logic       nrst;
    logic       ce;
    logic       read;
    logic       write;
    logic [7:0] address;
    logic [3:0] byteenable;
    cto_data_t  writedata;
    cto_data_t  readdata;
    cto_data_t  rd;
    logic       waitrequest;
    logic       irq;
    logic       module_output_pin;
    logic [15:0] toggles;
    int         n_fail;
    int         compares;

    cto_top i_cto_top (.clk(clk), .nrst(nrst), .ce(ce), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
        .waitrequest(waitrequest), .irq(irq), .module_output_pin(module_output_pin));
    cto_pin_mon i_cto_pin_mon (.clk(clk), .nrst(nrst),
        .module_output_pin(module_output_pin), .toggles(toggles));

    always #4 clk = ~clk;

    // ==================================================================
    // helpers
    task automatic stop_test;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string what, input cto_data_t exp, input cto_data_t got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [7:0] a, input cto_data_t d,
                       input logic [3:0] be);
        int n;
        @(posedge clk);
        address    <= a;
        writedata  <= d;
        byteenable <= be;
        write      <= wr;
        read       <= !wr;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0);
        chk("wait cycles", 32'h2, 32'(n));
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input cto_data_t d);
        bus(1'b1, a, d, 4'hF);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input cto_data_t exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(what, exp, rd);
    endtask

    // stop, load count+delta low byte first, high byte only if hi, restart
    task automatic arm(input int delta, input logic hi);
        logic [15:0] tgt;
        wr(`CTO_OFS_CTRL, 32'h0);
        bus(1'b0, `CTO_OFS_COUNT, 32'h0, 4'hF);
        tgt = rd[15:0] + 16'(delta);
        wr(`CTO_OFS_CMP_LO, {24'h0, tgt[7:0]});
        if (hi) wr(`CTO_OFS_CMP_HI, {24'h0, tgt[15:8]});
        wr(`CTO_OFS_CTRL, 32'h1);
    endtask

    task automatic watch(input int n, input logic irq_on);
        logic last;
        last = module_output_pin;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (module_output_pin !== last) chk("irq at toggle", {31'h0, irq_on}, {31'h0, irq});
            last = module_output_pin;
        end
    endtask

    // ==================================================================
    // scenarios
    task automatic t_reset;
        logic [7:0] ofs [9];
        ofs = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
        foreach (ofs[i]) rdchk("reset value", ofs[i], 32'h0);
        bus(1'b1, `CTO_OFS_IRQ_EN, 32'h1, 4'h0);
        rdchk("irq_en after be0", `CTO_OFS_IRQ_EN, 32'h0);
        wr(8'h24, 32'hFF);
        rdchk("unmapped", 8'h24, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_enable;
        wr(`CTO_OFS_MODE, 32'h7);
        wr(`CTO_OFS_CMP_LO, 32'h12);
        rdchk("mode after low", `CTO_OFS_MODE, 32'h6);
        wr(`CTO_OFS_CMP_HI, 32'h34);
        rdchk("mode after high", `CTO_OFS_MODE, 32'h7);
        rdchk("cmp low", `CTO_OFS_CMP_LO, 32'h12);
        $display("test enable done");
    endtask

    // 300 steps: a low-byte-only compare would hit early
    task automatic t_toggle;
        wr(`CTO_OFS_IRQ_EN, 32'h1);
        arm(300, 1'b1);
        watch(320, 1'b1);
        chk("toggles", 32'h1, {16'h0, toggles});
        rdchk("status", `CTO_OFS_STATUS, 32'h1);
        chk("irq", 32'h1, {31'h0, irq});
        rdchk("pin", `CTO_OFS_PIN, 32'h1);
        $display("test toggle done");
    endtask

    task automatic t_sticky;
        watch(100, 1'b1);
        rdchk("status kept", `CTO_OFS_STATUS, 32'h1);
        wr(`CTO_OFS_IRQ_CLR, 32'h1);
        rdchk("status cleared", `CTO_OFS_STATUS, 32'h0);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(`CTO_OFS_IRQ_EN, 32'h0);
        arm(30, 1'b1);
        watch(50, 1'b0);
        rdchk("status masked", `CTO_OFS_STATUS, 32'h1);
        chk("irq masked", 32'h0, {31'h0, irq});
        chk("toggles", 32'h2, {16'h0, toggles});
        wr(`CTO_OFS_IRQ_CLR, 32'h1);
        $display("test sticky done");
    endtask

    task automatic t_hold;
        arm(30, 1'b0);
        watch(50, 1'b0);
        chk("toggles held", 32'h2, {16'h0, toggles});
        rdchk("pin held", `CTO_OFS_PIN, 32'h0);
        rdchk("no flag", `CTO_OFS_STATUS, 32'h0);
        wr(`CTO_OFS_MODE, 32'h3);
        arm(30, 1'b1);
        watch(50, 1'b0);
        chk("no toggle select", 32'h2, {16'h0, toggles});
        rdchk("flag match only", `CTO_OFS_STATUS, 32'h1);
        wr(`CTO_OFS_IRQ_CLR, 32'h1);
        wr(`CTO_OFS_MODE, 32'h5);
        arm(30, 1'b1);
        watch(50, 1'b0);
        chk("no match select", 32'h2, {16'h0, toggles});
        rdchk("no flag", `CTO_OFS_STATUS, 32'h0);
        $display("test hold done");
    endtask

    // counter runs; only 3 enabled edges lie between the two snapshots
    task automatic t_freeze;
        logic [15:0] c1;
        bus(1'b0, `CTO_OFS_COUNT, 32'h0, 4'hF);
        c1 = rd[15:0];
        ce <= 1'b0;
        repeat (20) @(posedge clk);
        ce <= 1'b1;
        rdchk("count frozen", `CTO_OFS_COUNT, {16'h0, c1 + 16'h0003});
        $display("test freeze done");
    endtask

    // ==================================================================
    // main sequence and watchdog
    initial begin
        clk        = 1'b0;
        nrst       = 1'b0;
        ce         = 1'b1;
        read       = 1'b0;
        write      = 1'b0;
        address    = 8'h00;
        writedata  = 32'h0;
        byteenable = 4'hF;
        n_fail     = 0;
        compares   = 0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        t_reset();
        t_enable();
        t_toggle();
        t_sticky();
        t_hold();
        t_freeze();
        stop_test();
    end

    // tests take about 830 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        $display("MISMATCH watchdog expected end seen timeout");
        stop_test();
    end
endmodule
